// [core/dpllh_core.sv]
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "dpllh_regs.svh"
module dpllh_core #(
	parameter int TDC_W    = 24,
	parameter int STEP_W   = 32,
	parameter int AVG_LOG2 = 8
) (
	input  wire logic                     mclk_i,
	input  wire logic                     rst_i,
	input  wire logic                     ce_i,
	input  wire logic [8:0]               avs_address_i,
	input  wire logic                     avs_read_i,
	input  wire logic                     avs_write_i,
	input  wire logic [31:0]              avs_writedata_i,
	input  wire logic [3:0]               avs_byteenable_i,
	output logic      [31:0]              avs_readdata_o,
	output logic                          avs_waitrequest_o,
	input  wire logic                     update_i,
	input  wire logic                     sec_tick_i,
	input  wire logic                     input_sel_i,
	input  wire logic signed [TDC_W-1:0]  tdc_err_i,
	input  wire logic [23:0]              residual_i,
	input  wire logic signed [41:0]       freq_est_i,
	input  wire logic signed [STEP_W-1:0] phase_step_i,
	input  wire logic signed [STEP_W-1:0] integ_i,
	output logic signed [TDC_W-1:0]       phase_err_o,
	output logic signed [41:0]            holdover_freq_o,
	output logic signed [STEP_W-1:0]      phase_step_o,
	output logic signed [STEP_W-1:0]      integ_o,
	output logic                          result_valid_o
);
	localparam int ACC_W = 42 + AVG_LOG2;

	function automatic logic [7:0] byte_mask(input dpllh_pkg::dpllh_idx_t i);
		if (i == `DPLLH_IDX_CAP_TOP || i == `DPLLH_IDX_INTEG_TOP) begin
			return 8'h7f;
		end else if (i == `DPLLH_IDX_HVAL_TOP) begin
			return 8'h03;
		end else if (i == `DPLLH_IDX_S0_TOP || i == `DPLLH_IDX_S1_TOP) begin
			return 8'h3f;
		end else if (i <= `DPLLH_IDX_S1_TOP) begin
			return 8'hff;
		end else if (i >= `DPLLH_IDX_DEN1_LO && i <= `DPLLH_IDX_DEN1_TOP) begin
			return 8'hff;
		end else if (i >= `DPLLH_IDX_DEN0_LO && i <= `DPLLH_IDX_DEN0_TOP) begin
			return 8'hff;
		end
		return 8'h00;
	endfunction : byte_mask

	function automatic logic [7:0] reset_byte(input dpllh_pkg::dpllh_idx_t i);
		logic [31:0] lim;
		logic [47:0] hv;
		logic [15:0] s0;
		logic [15:0] s1;
		logic [23:0] dn;
		lim = {1'b0, `DPLLH_RST_LIMIT};
		hv  = {6'h00, `DPLLH_RST_HVAL};
		s0  = {2'h0, `DPLLH_RST_SCALE0};
		s1  = {2'h0, `DPLLH_RST_SCALE1};
		dn  = `DPLLH_RST_DEN;
		unique case (i) inside
			[6'd0:6'd3]:   return lim[8*i[1:0] +: 8];
			[6'd4:6'd7]:   return lim[8*i[1:0] +: 8];
			6'd8:          return `DPLLH_RST_BW;
			6'd9:          return `DPLLH_RST_MODE;
			[6'd10:6'd15]: return hv[8*(i-6'd10) +: 8];
			[6'd16:6'd17]: return s0[8*i[0] +: 8];
			[6'd18:6'd19]: return s1[8*i[0] +: 8];
			[6'd32:6'd34]: return dn[8*(i-6'd32) +: 8];
			[6'd36:6'd38]: return dn[8*(i-6'd36) +: 8];
			default:       return 8'h00;
		endcase
	endfunction : reset_byte

	// Bus slave: one wait cycle, then the answer.
	logic [7:0]  regb [0:`DPLLH_BYTES-1];
	logic [7:0]  next_regb [0:`DPLLH_BYTES-1];
	logic        wait_q;
	logic        next_wait;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic        req;
	logic        hit;
	logic        wr_go;
	logic [7:0]  wbyte;
	dpllh_pkg::dpllh_idx_t idx;
	logic [7:0]  status;

	// Committed copies that the loop uses.
	logic [30:0] cap_c;
	logic [30:0] integ_c;
	logic [41:0] hval_c;
	logic [13:0] s0_c;
	logic [13:0] s1_c;
	logic [23:0] den0_c;
	logic [23:0] den1_c;
	logic [30:0] next_cap;
	logic [30:0] next_integ;
	logic [41:0] next_hval;
	logic [13:0] next_s0;
	logic [13:0] next_s1;
	logic [23:0] next_den0;
	logic [23:0] next_den1;

	always_comb begin
		req   = avs_read_i | avs_write_i;
		hit   = avs_address_i >= `DPLLH_BASE_OFS && avs_address_i <= `DPLLH_LAST_OFS;
		idx   = 6'(avs_address_i - `DPLLH_BASE_OFS);
		wr_go = avs_write_i & ~wait_q & avs_byteenable_i[0] & hit;
		wbyte = avs_writedata_i[7:0] & byte_mask(idx);
		next_wait  = ~(req & wait_q);
		next_rdata = rdata;
		if (avs_read_i && wait_q) begin
			if (!hit) begin
				next_rdata = 32'h0000_0000;
			end else if (idx == `DPLLH_IDX_STATUS) begin
				next_rdata = {24'h00_0000, status};
			end else begin
				next_rdata = {24'h00_0000, regb[idx] & byte_mask(idx)};
			end
		end
		for (int i = 0; i < `DPLLH_BYTES; i++) begin
			next_regb[i] = regb[i];
		end
		if (wr_go && byte_mask(idx) != 8'h00) begin
			next_regb[idx] = wbyte;
		end
		next_cap   = cap_c;
		next_integ = integ_c;
		next_hval  = hval_c;
		next_s0    = s0_c;
		next_s1    = s1_c;
		next_den0  = den0_c;
		next_den1  = den1_c;
		if (wr_go) begin
			unique case (idx)
				`DPLLH_IDX_CAP_TOP:   next_cap   = {wbyte[6:0], regb[2], regb[1], regb[0]};
				`DPLLH_IDX_INTEG_TOP: next_integ = {wbyte[6:0], regb[6], regb[5], regb[4]};
				`DPLLH_IDX_HVAL_TOP:  next_hval  = {wbyte[1:0], regb[14], regb[13], regb[12],
						regb[11], regb[10]};
				`DPLLH_IDX_S0_TOP:    next_s0    = {wbyte[5:0], regb[16]};
				`DPLLH_IDX_S1_TOP:    next_s1    = {wbyte[5:0], regb[18]};
				`DPLLH_IDX_DEN1_TOP:  next_den1  = {wbyte, regb[33], regb[32]};
				`DPLLH_IDX_DEN0_TOP:  next_den0  = {wbyte, regb[37], regb[36]};
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			for (int i = 0; i < `DPLLH_BYTES; i++) begin
				regb[i] <= reset_byte(6'(i));
			end
			wait_q  <= 1'b1;
			rdata   <= 32'h0000_0000;
			cap_c   <= `DPLLH_RST_LIMIT;
			integ_c <= `DPLLH_RST_LIMIT;
			hval_c  <= `DPLLH_RST_HVAL;
			s0_c    <= `DPLLH_RST_SCALE0;
			s1_c    <= `DPLLH_RST_SCALE1;
			den0_c  <= `DPLLH_RST_DEN;
			den1_c  <= `DPLLH_RST_DEN;
		end else if (ce_i) begin
			for (int i = 0; i < `DPLLH_BYTES; i++) begin
				regb[i] <= next_regb[i];
			end
			wait_q  <= next_wait;
			rdata   <= next_rdata;
			cap_c   <= next_cap;
			integ_c <= next_integ;
			hval_c  <= next_hval;
			s0_c    <= next_s0;
			s1_c    <= next_s1;
			den0_c  <= next_den0;
			den1_c  <= next_den1;
		end
	end

	assign avs_readdata_o    = rdata;
	assign avs_waitrequest_o = wait_q;

	// Holdover filter, per-second history and loop outputs.
	logic [4:0]  bw_shift;
	logic [2:0]  bw_mult;
	logic [5:0]  hist_n;
	dpllh_pkg::dpllh_mode_e mode;
	logic signed [41:0] filt;
	logic signed [41:0] next_filt;
	logic signed [ACC_W-1:0] acc;
	logic signed [ACC_W-1:0] next_acc;
	logic signed [ACC_W-1:0] acc_sum;
	logic signed [42:0] diff;
	logic signed [46:0] prod;
	logic signed [46:0] step;
	logic [5:0]  sh;
	logic signed [41:0] hist_snap [0:`DPLLH_HIST_DEPTH-1];
	logic signed [41:0] hist_avg  [0:`DPLLH_HIST_DEPTH-1];
	logic [5:0]  wp;
	logic [5:0]  next_wp;
	logic [5:0]  rp;
	logic [6:0]  depth;
	logic [6:0]  next_depth;
	logic        hist_we;
	logic [23:0] den_sel;
	logic [13:0] scale_sel;
	logic [23:0] resid;
	logic [37:0] corr_full;
	logic signed [TDC_W-1:0] next_perr;
	logic signed [41:0] next_hfreq;
	logic signed [STEP_W-1:0] step_lim;
	logic signed [STEP_W-1:0] integ_lim;
	logic signed [TDC_W-1:0] perr;
	logic signed [41:0] hfreq;
	logic signed [STEP_W-1:0] step_q;
	logic signed [STEP_W-1:0] integ_q;
	logic        valid_q;

	always_comb begin
		bw_shift = regb[`DPLLH_IDX_BW][7:3];
		bw_mult  = regb[`DPLLH_IDX_BW][2:0];
		mode     = dpllh_pkg::dpllh_mode_e'(regb[`DPLLH_IDX_MODE][7:6]);
		hist_n   = regb[`DPLLH_IDX_MODE][5:0];
		status   = {5'h00, depth == 7'(`DPLLH_HIST_DEPTH), bw_mult == 3'h0, input_sel_i};
		diff = {freq_est_i[41], freq_est_i} - {filt[41], filt};
		prod = diff * $signed({1'b0, bw_mult});
		// Coefficient is mult/4 * 2^-(33-shift), so one arithmetic shift by 35-shift.
		sh   = `DPLLH_COE_SHIFT_BASE - {1'b0, bw_shift};
		step = prod >>> sh;
		next_filt = filt;
		if (update_i) begin
			if (bw_mult == 3'h0) begin
				next_filt = freq_est_i;
			end else begin
				next_filt = filt + step[41:0];
			end
		end
		// The averaging assumes 2^AVG_LOG2 - 1 updates per second plus the sample added on the tick cycle.
		acc_sum = acc + ACC_W'(filt);
		hist_we = sec_tick_i;
		next_acc = acc;
		if (sec_tick_i) begin
			next_acc = update_i ? ACC_W'(filt) : '0;
		end else if (update_i) begin
			next_acc = acc_sum;
		end
		next_wp    = hist_we ? 6'(wp + 6'h01) : wp;
		next_depth = depth;
		if (hist_we && depth != 7'(`DPLLH_HIST_DEPTH)) begin
			next_depth = 7'(depth + 7'h01);
		end
		rp = 6'(wp - 6'h01 - hist_n);
		unique case (mode)
			dpllh_pkg::DPLLH_HO_INST:      next_hfreq = filt;
			dpllh_pkg::DPLLH_HO_HIST_INST: next_hfreq = hist_snap[rp];
			dpllh_pkg::DPLLH_HO_MANUAL:    next_hfreq = $signed(hval_c);
			dpllh_pkg::DPLLH_HO_HIST_AVG:  next_hfreq = hist_avg[rp];
		endcase
		den_sel   = input_sel_i ? den1_c : den0_c;
		scale_sel = input_sel_i ? s1_c : s0_c;
		// A residual at or above the denominator can only be a stale sample.
		resid     = (residual_i < den_sel) ? residual_i : 24'h00_0000;
		corr_full = resid * scale_sel;
		next_perr = tdc_err_i - TDC_W'({1'b0, corr_full[37:`DPLLH_FRAC_BITS]});
	end

	dpllh_clamp #(.W(STEP_W)) u_slope_clamp (
		.value_i (phase_step_i),
		.limit_i (cap_c),
		.value_o (step_lim)
	);

	dpllh_clamp #(.W(STEP_W)) u_integ_clamp (
		.value_i (integ_i),
		.limit_i (integ_c),
		.value_o (integ_lim)
	);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			filt    <= '0;
			acc     <= '0;
			wp      <= 6'h00;
			depth   <= 7'h00;
			perr    <= '0;
			hfreq   <= '0;
			step_q  <= '0;
			integ_q <= '0;
			valid_q <= 1'b0;
		end else if (ce_i) begin
			filt    <= next_filt;
			acc     <= next_acc;
			wp      <= next_wp;
			depth   <= next_depth;
			hfreq   <= next_hfreq;
			valid_q <= update_i;
			if (update_i) begin
				perr    <= next_perr;
				step_q  <= step_lim;
				integ_q <= integ_lim;
			end
		end
	end

	// History memory has no reset; depth tells how much of it is real.
	always_ff @(posedge mclk_i) begin
		if (ce_i && hist_we) begin
			hist_snap[wp] <= filt;
			hist_avg[wp]  <= acc_sum[AVG_LOG2 +: 42];
		end
	end

	assign phase_err_o     = perr;
	assign holdover_freq_o = hfreq;
	assign phase_step_o    = step_q;
	assign integ_o         = integ_q;
	assign result_valid_o  = valid_q;
endmodule : dpllh_core

// [common/dpllh_regs.svh]
`ifndef DPLLH_REGS_SVH
`define DPLLH_REGS_SVH

`define DPLLH_BASE_OFS     9'h14c
`define DPLLH_LAST_OFS     9'h174
`define DPLLH_BYTES        41
`define DPLLH_OFS_CAP      9'h14c
`define DPLLH_OFS_INTEG    9'h150
`define DPLLH_OFS_BW       9'h154
`define DPLLH_OFS_MODE     9'h155
`define DPLLH_OFS_HVAL     9'h156
`define DPLLH_OFS_SCALE0   9'h15c
`define DPLLH_OFS_SCALE1   9'h15e
`define DPLLH_OFS_DEN1     9'h16c
`define DPLLH_OFS_DEN0     9'h170
`define DPLLH_OFS_STATUS   9'h174

`define DPLLH_IDX_CAP_TOP   6'd3
`define DPLLH_IDX_INTEG_TOP 6'd7
`define DPLLH_IDX_BW        6'd8
`define DPLLH_IDX_MODE      6'd9
`define DPLLH_IDX_HVAL_TOP  6'd15
`define DPLLH_IDX_S0_TOP    6'd17
`define DPLLH_IDX_S1_TOP    6'd19
`define DPLLH_IDX_DEN1_LO   6'd32
`define DPLLH_IDX_DEN1_TOP  6'd34
`define DPLLH_IDX_DEN0_LO   6'd36
`define DPLLH_IDX_DEN0_TOP  6'd38
`define DPLLH_IDX_STATUS    6'd40

`define DPLLH_RST_LIMIT     31'h7fffffff
`define DPLLH_RST_BW        8'h44
`define DPLLH_RST_MODE      8'h00
`define DPLLH_RST_HVAL      42'h000_0000_0000
`define DPLLH_RST_SCALE0    14'h0055
`define DPLLH_RST_SCALE1    14'h0055
`define DPLLH_RST_DEN       24'h800000

`define DPLLH_COE_SHIFT_BASE 6'd35
`define DPLLH_FRAC_BITS      24
`define DPLLH_HIST_DEPTH     64

`endif

// [common/dpllh_pkg.sv]
package dpllh_pkg;
	typedef enum logic [1:0] {
		DPLLH_HO_INST      = 2'b00,
		DPLLH_HO_HIST_INST = 2'b01,
		DPLLH_HO_MANUAL    = 2'b10,
		DPLLH_HO_HIST_AVG  = 2'b11
	} dpllh_mode_e;
	typedef logic [5:0] dpllh_idx_t;
endpackage : dpllh_pkg

// [core/dpllh_clamp.sv]
`timescale 1ns/1ps
module dpllh_clamp #(
	parameter int W = 32
) (
	input  wire logic signed [W-1:0] value_i,
	input  wire logic        [30:0]  limit_i,
	output logic signed      [W-1:0] value_o
);
	logic signed [W-1:0] pos_lim;
	logic signed [W-1:0] neg_lim;

	always_comb begin
		pos_lim = W'({1'b0, limit_i});
		neg_lim = -pos_lim;
		if (value_i > pos_lim) begin
			value_o = pos_lim;
		end else if (value_i < neg_lim) begin
			value_o = neg_lim;
		end else begin
			value_o = value_i;
		end
	end
endmodule : dpllh_clamp

// [bench/dpllh_core_checker.sv]
`timescale 1ns/1ps
`include "dpllh_regs.svh"
module dpllh_checker #(
	parameter int TDC_W  = 24,
	parameter int STEP_W = 32
) (
	input wire logic                     mclk_i,
	input wire logic                     rst_i,
	input wire logic                     ce_i,
	input wire logic [8:0]               avs_address_i,
	input wire logic                     avs_read_i,
	input wire logic                     avs_write_i,
	input wire logic [31:0]              avs_readdata_o,
	input wire logic                     avs_waitrequest_o,
	input wire logic                     update_i,
	input wire logic signed [STEP_W-1:0] phase_step_i,
	input wire logic signed [TDC_W-1:0]  phase_err_o,
	input wire logic signed [STEP_W-1:0] phase_step_o,
	input wire logic                     result_valid_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_answer;
		s_take ##1 !avs_waitrequest_o;
	endsequence
	bus_answer_a: assert property (s_take |=> !avs_waitrequest_o)
		else $error("bus request not answered");
	answer_pulse_a: assert property (s_answer |=> avs_waitrequest_o)
		else $error("bus answer longer than one cycle");
	unmapped_zero_a: assert property (s_take ##0 (avs_read_i && (avs_address_i <
		`DPLLH_BASE_OFS || avs_address_i > `DPLLH_LAST_OFS)) |=> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	upper_zero_a: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	rd_hold_a: assert property (avs_waitrequest_o && !$past(rst_i) |-> $stable(avs_readdata_o))
		else $error("read data changed without answer");
	valid_after_a: assert property (ce_i && update_i |=> result_valid_o)
		else $error("no result after update");
	valid_cause_a: assert property (result_valid_o |-> $past(update_i && ce_i))
		else $error("result without update");
	out_hold_a: assert property (!result_valid_o && !$past(rst_i) |->
		$stable(phase_step_o) && $stable(phase_err_o))
		else $error("loop output changed between updates");
	step_pos_a: assert property (result_valid_o && $past(phase_step_i) >= 0 |->
		phase_step_o >= 0 && phase_step_o <= $past(phase_step_i))
		else $error("positive phase step not clamped");
	step_neg_a: assert property (result_valid_o && $past(phase_step_i) < 0 |->
		phase_step_o <= 0 && phase_step_o >= $past(phase_step_i))
		else $error("negative phase step not clamped");
endmodule : dpllh_checker
bind dpllh_core dpllh_checker #(.TDC_W(TDC_W), .STEP_W(STEP_W)) u_chk (.mclk_i(mclk_i),
	.rst_i(rst_i), .ce_i(ce_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .update_i(update_i), .phase_step_i(phase_step_i),
	.phase_err_o(phase_err_o), .phase_step_o(phase_step_o), .result_valid_o(result_valid_o));

// [bench/dpllh_core_tb_top.sv]
`timescale 1ns/1ps
module dpllh_core_tb_top;
	logic               mclk_i = 1'b0;
	logic               rst_i = 1'b1;
	logic               ce_i = 1'b1;
	logic [8:0]         avs_address_i = 9'h0;
	logic               avs_read_i = 1'b0;
	logic               avs_write_i = 1'b0;
	logic [31:0]        avs_writedata_i = 32'h0;
	logic [31:0]        avs_readdata_o;
	logic               avs_waitrequest_o;
	logic               update_i = 1'b0;
	logic               sec_tick_i = 1'b0;
	logic               input_sel_i = 1'b0;
	logic signed [23:0] tdc_err_i = 24'sh0;
	logic [23:0]        residual_i = 24'h0;
	logic signed [41:0] freq_est_i = 42'sh0;
	logic signed [31:0] phase_step_i = 32'sh0;
	logic signed [31:0] integ_i = 32'sh0;
	logic signed [23:0] phase_err_o;
	logic signed [41:0] holdover_freq_o;
	logic signed [31:0] phase_step_o;
	logic signed [31:0] integ_o;
	logic               result_valid_o;
	logic [7:0]         q;
	int                 fails = 0;
	int                 n_tests = 0;
	always #10 mclk_i = ~mclk_i;
	dpllh_core #(.AVG_LOG2(2)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'h1),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.update_i(update_i), .sec_tick_i(sec_tick_i), .input_sel_i(input_sel_i),
		.tdc_err_i(tdc_err_i), .residual_i(residual_i), .freq_est_i(freq_est_i),
		.phase_step_i(phase_step_i), .integ_i(integ_i), .phase_err_o(phase_err_o),
		.holdover_freq_o(holdover_freq_o), .phase_step_o(phase_step_o), .integ_o(integ_o),
		.result_valid_o(result_valid_o));
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// The request is held until waitrequest is seen low; a hang is left to the watchdog.
	task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d,
		output logic [7:0] r);
		avs_address_i <= a;
		avs_writedata_i <= {24'h0, d};
		avs_write_i <= w;
		avs_read_i <= !w;
		do begin
			@(posedge mclk_i);
		end while (avs_waitrequest_o !== 1'b0);
		r = avs_readdata_o[7:0];
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge mclk_i);
	endtask : bus
	task automatic wrn(input logic [8:0] a, input logic [63:0] v, input int n);
		logic [7:0] r;
		for (int i = 0; i < n; i++) bus(1'b1, a + 9'(i), v[8*i+:8], r);
		// The holdover output follows a new mode one edge later, so let that edge pass.
		@(posedge mclk_i);
	endtask : wrn
	task automatic pulse(input logic t);
		if (t) sec_tick_i <= 1'b1; else update_i <= 1'b1;
		@(posedge mclk_i);
		sec_tick_i <= 1'b0;
		update_i <= 1'b0;
		@(negedge mclk_i);
		chk(result_valid_o, !t && ce_i);
		repeat (3) @(posedge mclk_i);
	endtask : pulse
	task automatic t_rst;
		logic [8:0] a[10] = '{9'h14c, 9'h14f, 9'h150, 9'h153, 9'h154, 9'h155, 9'h156,
			9'h15e, 9'h16e, 9'h100};
		logic [7:0] e[10] = '{8'hff, 8'h7f, 8'hff, 8'h7f, 8'h44, 8'h00, 8'h00, 8'h55,
			8'h80, 8'h00};
		for (int i = 0; i < 10; i++) begin
			bus(1'b0, a[i], 8'h0, q);
			chk(q, e[i]);
		end
		$display("t_rst done");
	endtask : t_rst
	task automatic t_clamp;
		wrn(9'h14c, 64'h10, 1);
		phase_step_i <= 32'sd100;
		pulse(1'b0);
		chk(phase_step_o, 64'd100);
		wrn(9'h14d, 64'h0, 3);
		wrn(9'h150, 64'h20, 4);
		integ_i <= 32'sd1000;
		pulse(1'b0);
		chk(phase_step_o, 64'd16);
		chk(integ_o, 64'd32);
		phase_step_i <= -32'sd100;
		integ_i <= -32'sd5;
		pulse(1'b0);
		chk(phase_step_o, -64'sd16);
		chk(integ_o, -64'sd5);
		// With the clock enable low an update must leave phase_step_o as it was and result_valid_o low.
		ce_i <= 1'b0;
		phase_step_i <= 32'sd50;
		pulse(1'b0);
		chk(phase_step_o, -64'sd16);
		ce_i <= 1'b1;
		$display("t_clamp done");
	endtask : t_clamp
	task automatic t_pec;
		wrn(9'h15c, 64'h100, 2);
		residual_i <= 24'h100000;
		tdc_err_i <= 24'sh100;
		pulse(1'b0);
		chk(phase_err_o, 64'hf0);
		input_sel_i <= 1'b1;
		pulse(1'b0);
		chk(phase_err_o, 64'hfb);
		$display("t_pec done");
	endtask : t_pec
	task automatic t_mode;
		wrn(9'h154, 64'h40, 1);
		freq_est_i <= 42'sh123;
		pulse(1'b0);
		chk(holdover_freq_o, 64'h123);
		wrn(9'h154, 64'h44, 1);
		freq_est_i <= 42'sh100000000;
		pulse(1'b0);
		chk(holdover_freq_o, 64'h1a2);
		wrn(9'h156, 64'h2aabbccdd11, 6);
		wrn(9'h155, 64'h80, 1);
		chk(holdover_freq_o, 42'sh2aabbccdd11);
		$display("t_mode done");
	endtask : t_mode
	task automatic t_hist;
		wrn(9'h154, 64'h40, 1);
		freq_est_i <= 42'sh77;
		pulse(1'b0);
		pulse(1'b1);
		freq_est_i <= 42'sh99;
		pulse(1'b0);
		pulse(1'b1);
		wrn(9'h155, 64'h41, 1);
		chk(holdover_freq_o, 64'h77);
		wrn(9'h155, 64'h40, 1);
		chk(holdover_freq_o, 64'h99);
		for (int m = 0; m < 4; m++) begin
			wrn(9'h155, {56'h0, m[1:0], 6'h3f}, 1);
			bus(1'b0, 9'h155, 8'h0, q);
			chk(q, {56'h0, m[1:0], 6'h3f});
		end
		// One second of four equal samples must average back to the same frequency.
		pulse(1'b1);
		repeat (3) pulse(1'b0);
		pulse(1'b1);
		wrn(9'h155, 64'hc0, 1);
		chk(holdover_freq_o, 64'h99);
		bus(1'b0, 9'h174, 8'h0, q);
		chk(q, 64'h03);
		$display("t_hist done");
	endtask : t_hist
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		t_rst();
		t_clamp();
		t_pec();
		t_mode();
		t_hist();
		stop_test();
	end
	initial begin
		repeat (5000) @(posedge mclk_i);
		fails++;
		stop_test();
	end
endmodule : dpllh_core_tb_top
